//--- core/pri_defines.vh
`ifndef PRI_DEFINES_VH
`define PRI_DEFINES_VH

// ------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------
`define PRI_CLK_HZ        50000000
`define PRI_TICK_S        1
`define PRI_TICK_CYC      26'h2FAF080
`define PRI_DEB_MS        10
`define PRI_DEB_CYC       20'h7A120
`define PRI_SYNC_CYC      21'h000002

// ------------------------------------------------------------
// Delay settings, in seconds
// ------------------------------------------------------------
`define PRI_DLY_SHORT_S   11'd180
`define PRI_DLY_MID_S     11'd600
`define PRI_DLY_LONG_S    11'd1800
`define PRI_OC_HOLD_S     11'd180
`define PRI_SCR_STEP_S    11'd2

// ------------------------------------------------------------
// Switch bank bit positions (switch n at bit n-1)
// ------------------------------------------------------------
`define PRI_SW_RS_INV     0
`define PRI_SW_LW_INV     1
`define PRI_SW_DLY_MID    2
`define PRI_SW_DLY_LONG   3
`define PRI_SW_FREEZE     6

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PRI_REG_CTRL      3'h0
`define PRI_REG_STATE     3'h1
`define PRI_REG_SWITCH    3'h2
`define PRI_REG_INT_STAT  3'h3
`define PRI_REG_INT_MASK  3'h4
`define PRI_REG_HOLD_LO   3'h5
`define PRI_REG_HOLD_HI   3'h6

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define PRI_CTRL_RUN_EN   0
`define PRI_CTRL_RST      8'h01
`define PRI_MASK_RST      8'h00
`define PRI_INT_OC        0
`define PRI_INT_STOP      1
`define PRI_INT_START     2
`define PRI_ST_RUN        0
`define PRI_ST_RS         1
`define PRI_ST_LW         2
`define PRI_ST_OC         3
`define PRI_ST_HOLD       4

`endif

//--- core/pri_debounce.v
`timescale 1ns/1ps
`default_nettype none

module pri_debounce #(
  parameter        W   = 1,
  parameter [19:0] CNT = 20'h00010
) (
  input  wire         sys_clk_i,
  input  wire         rst_sync_b_i,
  input  wire [W-1:0] raw_i,
  output reg  [W-1:0] clean_o
);

  // ----------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------
  reg [W-1:0] sync_a;
  reg [W-1:0] sync_b;
  reg [19:0]  stable_cnt;

  always @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      sync_a <= {W{1'b0}};
      sync_b <= {W{1'b0}};
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------
  // Accept a new value once the input has differed from the output for CNT cycles
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b_i) begin
    if (!rst_sync_b_i) begin
      stable_cnt <= 20'h00000;
      clean_o    <= {W{1'b0}};
    end else if (sync_b == clean_o) begin
      stable_cnt <= 20'h00000;
    end else if (stable_cnt >= CNT - 20'h00001) begin
      stable_cnt <= 20'h00000;
      clean_o    <= sync_b;
    end else begin
      stable_cnt <= stable_cnt + 20'h00001;
    end
  end

endmodule

`default_nettype wire

//--- core/pri_interlock.v
`timescale 1ns/1ps
`default_nettype none
`include "pri_defines.vh"

module pri_interlock #(
  parameter        DISPLAY_VARIANT = 0,
  parameter [25:0] TICK_CYC        = `PRI_TICK_CYC,
  parameter [19:0] DEB_CYC         = `PRI_DEB_CYC
) (
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire [7:0] cfg_sw_i,
  input  wire       remote_sense_in_i,
  input  wire       water_probe_in_i,
  input  wire       over_current_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_stb_i,
  input  wire       rd_stb_i,
  output reg  [7:0] rd_data_o,
  output reg        motor_run_o,
  output reg        remote_stop_indicator_o,
  output reg        error_led_o,
  output reg        oc_message_o,
  output reg  [1:0] screen_sel_o,
  output wire       irq_o
);

  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  localparam [0:0] ST_NORMAL = 1'b0;
  localparam [0:0] ST_OC     = 1'b1;

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  reg         rst_a;
  reg         rst_sync_b;
  reg         oc_a;
  reg         oc_b;
  wire [7:0]  sw;
  wire [1:0]  contacts;
  reg  [25:0] tick_cnt;
  reg         tick;
  reg  [0:0]  state;
  reg  [0:0]  next_state;
  reg  [10:0] oc_cnt;
  reg  [10:0] hold_cnt;
  reg  [10:0] dly_sel;
  reg  [10:0] scr_cnt;
  reg  [20:0] settle_cnt;
  reg         settled;
  reg         remote_stop_indicator;
  reg         lw_stop;
  wire        stop_req;
  reg         stop_q;
  wire        run_now;
  reg  [7:0]  ctrl;
  reg  [7:0]  int_stat;
  reg  [7:0]  int_mask;
  reg  [7:0]  int_set;
  reg  [7:0]  next_rd;

  // ----------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_a      <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_a      <= 1'b1;
      rst_sync_b <= rst_a;
    end
  end

  // ----------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------
  pri_debounce #(
    .W   (8),
    .CNT (DEB_CYC)
  ) u_sw_deb (
    .sys_clk_i    (sys_clk_i),
    .rst_sync_b_i (rst_sync_b),
    .raw_i        (cfg_sw_i),
    .clean_o      (sw)
  );

  pri_debounce #(
    .W   (2),
    .CNT (DEB_CYC)
  ) u_contact_deb (
    .sys_clk_i    (sys_clk_i),
    .rst_sync_b_i (rst_sync_b),
    .raw_i        ({water_probe_in_i, remote_sense_in_i}),
    .clean_o      (contacts)
  );

  // Over-current is only synchronised, for fast reaction
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      oc_a <= 1'b0;
      oc_b <= 1'b0;
    end else begin
      oc_a <= over_current_i;
      oc_b <= oc_a;
    end
  end

  // ----------------------------------------------------------
  // Hold drive off until debounced inputs are valid
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      settle_cnt <= 21'h000000;
      settled    <= 1'b0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 21'h000001;
      if (settle_cnt >= {1'b0, DEB_CYC} + `PRI_SYNC_CYC)
        settled <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // One-second tick
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tick_cnt <= 26'h0000000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC - 26'h0000001) begin
      tick_cnt <= 26'h0000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 26'h0000001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Stop decision
  // ----------------------------------------------------------
  always @* begin
    if (sw[`PRI_SW_RS_INV])
      remote_stop_indicator = ~contacts[0];
    else
      remote_stop_indicator = contacts[0];
    if (DISPLAY_VARIANT == 0 && sw[`PRI_SW_LW_INV])
      lw_stop = ~contacts[1];
    else
      lw_stop = contacts[1];
  end

  assign stop_req = remote_stop_indicator | lw_stop;

  // Base variant: longest setting wins when both are on; display variant always uses the short delay
  always @* begin
    if (DISPLAY_VARIANT != 0)
      dly_sel = `PRI_DLY_SHORT_S;
    else if (sw[`PRI_SW_DLY_LONG])
      dly_sel = `PRI_DLY_LONG_S;
    else if (sw[`PRI_SW_DLY_MID])
      dly_sel = `PRI_DLY_MID_S;
    else
      dly_sel = `PRI_DLY_SHORT_S;
  end

  // ----------------------------------------------------------
  // Restart delay
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_cnt <= 11'h000;
      stop_q   <= 1'b0;
    end else begin
      stop_q <= stop_req;
      if (stop_req)
        hold_cnt <= dly_sel;
      else if (tick && hold_cnt != 11'h000)
        hold_cnt <= hold_cnt - 11'h001;
    end
  end

  // ----------------------------------------------------------
  // Over-current state machine
  // ----------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (oc_b && motor_run_o)
          next_state = ST_OC;
      end
      ST_OC: begin
        if (tick && oc_cnt == 11'h001)
          next_state = ST_NORMAL;
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state  <= ST_NORMAL;
      oc_cnt <= 11'h000;
    end else begin
      state <= next_state;
      if (state == ST_NORMAL)
        oc_cnt <= `PRI_OC_HOLD_S;
      else if (tick && oc_cnt != 11'h000)
        oc_cnt <= oc_cnt - 11'h001;
    end
  end

  assign run_now = (state == ST_NORMAL) && (next_state == ST_NORMAL)
                   && !stop_req && hold_cnt == 11'h000
                   && ctrl[`PRI_CTRL_RUN_EN]
                   && settled;

  // ----------------------------------------------------------
  // Indicator and drive outputs
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      motor_run_o             <= 1'b0;
      remote_stop_indicator_o <= 1'b0;
      error_led_o             <= 1'b0;
      oc_message_o            <= 1'b0;
    end else begin
      motor_run_o             <= run_now;
      remote_stop_indicator_o <= stop_req
                                 || hold_cnt != 11'h000;
      error_led_o             <= next_state == ST_OC;
      oc_message_o            <= next_state == ST_OC;
    end
  end

  // ----------------------------------------------------------
  // Screen stepping
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scr_cnt      <= 11'h000;
      screen_sel_o <= 2'h0;
    end else if (DISPLAY_VARIANT != 0 && !sw[`PRI_SW_FREEZE]
                 && tick) begin
      if (scr_cnt >= `PRI_SCR_STEP_S - 11'h001) begin
        scr_cnt      <= 11'h000;
        screen_sel_o <= screen_sel_o + 2'h1;
      end else begin
        scr_cnt <= scr_cnt + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------
  always @* begin
    int_set                 = 8'h00;
    int_set[`PRI_INT_OC]    = (state == ST_NORMAL)
                              && (next_state == ST_OC);
    int_set[`PRI_INT_STOP]  = stop_req && !stop_q;
    int_set[`PRI_INT_START] = run_now && !motor_run_o;
  end

  assign irq_o = |(int_stat & int_mask);

  // ----------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl     <= `PRI_CTRL_RST;
      int_mask <= `PRI_MASK_RST;
      int_stat <= 8'h00;
    end else begin
      if (wr_stb_i && addr_i == `PRI_REG_CTRL)
        ctrl <= wr_data_i & 8'h01;
      if (wr_stb_i && addr_i == `PRI_REG_INT_MASK)
        int_mask <= wr_data_i & 8'h07;
      // Set wins over write-one-to-clear
      if (wr_stb_i && addr_i == `PRI_REG_INT_STAT)
        int_stat <= (int_stat & ~wr_data_i) | int_set;
      else
        int_stat <= int_stat | int_set;
    end
  end

  // ----------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------
  always @* begin
    next_rd = 8'h00;
    case (addr_i)
      `PRI_REG_CTRL:     next_rd = ctrl;
      `PRI_REG_STATE: begin
        next_rd[`PRI_ST_RUN]  = motor_run_o;
        next_rd[`PRI_ST_RS]   = remote_stop_indicator;
        next_rd[`PRI_ST_LW]   = lw_stop;
        next_rd[`PRI_ST_OC]   = state == ST_OC;
        next_rd[`PRI_ST_HOLD] = hold_cnt != 11'h000;
        next_rd[6:5]          = screen_sel_o;
      end
      `PRI_REG_SWITCH:   next_rd = sw;
      `PRI_REG_INT_STAT: next_rd = int_stat;
      `PRI_REG_INT_MASK: next_rd = int_mask;
      `PRI_REG_HOLD_LO:  next_rd = hold_cnt[7:0];
      `PRI_REG_HOLD_HI:  next_rd = {5'h00, hold_cnt[10:8]};
      default:           next_rd = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b)
      rd_data_o <= 8'h00;
    else if (rd_stb_i)
      rd_data_o <= next_rd;
    else
      rd_data_o <= 8'h00;
  end

endmodule

`default_nettype wire

//--- tb/pri_field_contacts.sv
`timescale 1ns/1ps
`default_nettype none

module pri_field_contacts #(
  parameter DISPLAY = 0
) (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] sw_req_i,
  input  wire logic       freeze_i,
  input  wire logic       rs_closed_i,
  input  wire logic       probe_wet_i,
  input  wire logic       bounce_i,
  output logic      [7:0] cfg_sw_o,
  output logic            remote_sense_in_o,
  output logic            water_probe_in_o
);
  logic [1:0] bounce_cnt = 2'h0;

  // ----------------------------------------
  // Switch bank, unused positions held off
  // ----------------------------------------
  assign cfg_sw_o = DISPLAY ? {1'b0, freeze_i, 5'h00, sw_req_i[0]}
                            : {4'h0, sw_req_i};

  // ----------------------------------------
  // Contact chatter, two cycles long
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (bounce_i) begin
      bounce_cnt <= 2'h2;
    end else if (bounce_cnt != 2'h0) begin
      bounce_cnt <= bounce_cnt - 2'h1;
    end
  end

  assign remote_sense_in_o = rs_closed_i ^ (bounce_cnt != 2'h0);
  assign water_probe_in_o  = probe_wet_i;
endmodule

`default_nettype wire

//--- tb/pri_interlock_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pri_interlock_chk #(
  parameter        DISPLAY_VARIANT = 0,
  parameter [25:0] TICK_CYC        = 26'd10,
  parameter [19:0] DEB_CYC         = 20'd4
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] cfg_sw_i,
  input wire logic       remote_sense_in_i,
  input wire logic       water_probe_in_i,
  input wire logic       over_current_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_stb_i,
  input wire logic       rd_stb_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       motor_run_o,
  input wire logic       remote_stop_indicator_o,
  input wire logic       error_led_o,
  input wire logic       oc_message_o,
  input wire logic [1:0] screen_sel_o,
  input wire logic       irq_o
);
  int unsigned oc_cnt;
  int unsigned stop_cnt;
  int unsigned frz_cnt;
  wire logic   stop_raw = (remote_sense_in_i ^ cfg_sw_i[0]) |
                          (water_probe_in_i ^ cfg_sw_i[1]);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_cnt   <= 0;
      stop_cnt <= 0;
      frz_cnt  <= 0;
    end else begin
      oc_cnt   <= error_led_o ? oc_cnt + 1 : 0;
      stop_cnt <= (stop_raw && $stable(cfg_sw_i)) ? stop_cnt + 1 : 0;
      frz_cnt  <= cfg_sw_i[6] ? frz_cnt + 1 : 0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rd_idle_zero_a: assert property (!rd_stb_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read");
  oc_msg_pair_a: assert property (error_led_o == oc_message_o)
    else $error("over-current light and message differ");
  oc_trip_stop_a: assert property ($rose(error_led_o) |->
      !motor_run_o && $past(motor_run_o))
    else $error("over-current trip without a running drive");
  oc_no_run_a: assert property (error_led_o |-> !motor_run_o)
    else $error("drive on during over-current hold");
  oc_hold_len_a: assert property ($fell(error_led_o) |->
      oc_cnt >= 179 * TICK_CYC && oc_cnt <= 180 * TICK_CYC + 2)
    else $error("over-current hold length wrong");
  stop_blocks_a: assert property (DISPLAY_VARIANT == 0 &&
      stop_cnt == DEB_CYC + 10 |->
      remote_stop_indicator_o && !motor_run_o)
    else $error("stop condition not blocking the drive");
  ind_stops_run_a: assert property ($rose(remote_stop_indicator_o) |->
      ##[0:2] !motor_run_o)
    else $error("stop light on while drive keeps running");
  screen_base_a: assert property (DISPLAY_VARIANT == 0 |->
      screen_sel_o == 2'b00)
    else $error("screen index moves on base variant");
  freeze_hold_a: assert property (DISPLAY_VARIANT == 1 &&
      frz_cnt > DEB_CYC + 10 |=> $stable(screen_sel_o))
    else $error("screen advanced while frozen");

  cover property ($rose(error_led_o));
  cover property ($rose(remote_stop_indicator_o));
  cover property ($rose(motor_run_o));
  cover property (DISPLAY_VARIANT == 1 && frz_cnt == DEB_CYC + 11);
endmodule

bind pri_interlock pri_interlock_chk #(
  .DISPLAY_VARIANT(DISPLAY_VARIANT), .TICK_CYC(TICK_CYC), .DEB_CYC(DEB_CYC)
) chk_u (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_sw_i(cfg_sw_i),
  .remote_sense_in_i(remote_sense_in_i), .water_probe_in_i(water_probe_in_i),
  .over_current_i(over_current_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
  .motor_run_o(motor_run_o),
  .remote_stop_indicator_o(remote_stop_indicator_o),
  .error_led_o(error_led_o), .oc_message_o(oc_message_o),
  .screen_sel_o(screen_sel_o), .irq_o(irq_o)
);

`default_nettype wire

//--- tb/test_pri_interlock.sv
`timescale 1ns/1ps
`default_nettype none

module test_pri_interlock;
  localparam int TK = 10;
  localparam int DB = 4;
  logic       sys_clk_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [3:0] sw_req    = 4'h0;
  logic       want_rs   = 1'b0;
  logic       want_wet  = 1'b0;
  logic       bounce    = 1'b0;
  logic       oc_in     = 1'b0;
  logic [2:0] addr      = 3'h0;
  logic [7:0] wdat      = 8'h00;
  logic       wstb      = 1'b0;
  logic       rstb      = 1'b0;
  wire  [7:0] cfg_sw;
  wire  [7:0] rdat;
  wire        rs_in;
  wire        probe_in;
  wire        motor;
  wire        ind;
  wire        err;
  wire        msg;
  wire        irq;
  wire  [7:0] cfg_sw_d;
  wire        rs_in_d;
  wire        probe_in_d;
  wire  [1:0] scr_b;
  wire  [1:0] scr_d;
  logic       frz       = 1'b0;
  logic [1:0] s0;
  int         errors    = 0;
  int         cmp_count = 0;
  int         n;
  logic [3:0] cfg_t [6] = '{4'h0, 4'h1, 4'h4, 4'h2, 4'hC, 4'h8};
  bit         prb_t [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  int         tk_t  [6] = '{180, 180, 600, 180, 1800, 1800};

  always #10 sys_clk_i = ~sys_clk_i;

  pri_field_contacts fc_u (
    .sys_clk_i(sys_clk_i), .sw_req_i(sw_req), .freeze_i(frz),
    .rs_closed_i(want_rs),
    .probe_wet_i(want_wet), .bounce_i(bounce), .cfg_sw_o(cfg_sw),
    .remote_sense_in_o(rs_in), .water_probe_in_o(probe_in)
  );

  pri_field_contacts #(.DISPLAY(1)) fc_d_u (
    .sys_clk_i(sys_clk_i), .sw_req_i(sw_req), .freeze_i(frz),
    .rs_closed_i(want_rs), .probe_wet_i(want_wet), .bounce_i(bounce),
    .cfg_sw_o(cfg_sw_d), .remote_sense_in_o(rs_in_d),
    .water_probe_in_o(probe_in_d)
  );

  pri_interlock #(.DISPLAY_VARIANT(0), .TICK_CYC(26'd10), .DEB_CYC(20'd4))
  dut_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_sw_i(cfg_sw),
    .remote_sense_in_i(rs_in), .water_probe_in_i(probe_in),
    .over_current_i(oc_in), .addr_i(addr), .wr_data_i(wdat),
    .wr_stb_i(wstb), .rd_stb_i(rstb), .rd_data_o(rdat),
    .motor_run_o(motor), .remote_stop_indicator_o(ind),
    .error_led_o(err), .oc_message_o(msg), .screen_sel_o(scr_b),
    .irq_o(irq)
  );

  pri_interlock #(.DISPLAY_VARIANT(1), .TICK_CYC(26'd10), .DEB_CYC(20'd4))
  dut_d_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_sw_i(cfg_sw_d),
    .remote_sense_in_i(rs_in_d), .water_probe_in_i(probe_in_d),
    .over_current_i(oc_in), .addr_i(addr), .wr_data_i(wdat),
    .wr_stb_i(wstb), .rd_stb_i(rstb), .rd_data_o(),
    .motor_run_o(), .remote_stop_indicator_o(), .error_led_o(),
    .oc_message_o(), .screen_sel_o(scr_d), .irq_o()
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdat <= d;
    wstb <= 1'b1;
    @(posedge sys_clk_i);
    wstb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rstb <= 1'b1;
    @(posedge sys_clk_i);
    rstb <= 1'b0;
    #1 chk(rdat, e);
  endtask

  task automatic wait_sig(input bit oc, input logic v, input int lim,
                          output int cyc);
    cyc = 0;
    while ((oc ? err : motor) !== v && cyc < lim) begin
      @(posedge sys_clk_i);
      #1 cyc++;
    end
    if (cyc >= lim) begin
      errors++;
      $display("mismatch at %0t: waited %0h of %0h", $time, cyc, lim);
      conclude();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rd(3'h0, 8'h01);
    rd(3'h4, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wait_sig(0, 1'b1, 200, n);
    #1 chk(irq, 1'b0);
    rd(3'h3, 8'h04);
    wr(3'h4, 8'h07);
    rd(3'h4, 8'h07);
    #1 chk(irq, 1'b1);
    wr(3'h3, 8'h04);
    #1 chk(irq, 1'b0);
    rd(3'h3, 8'h00);
    $display("test registers done");
    chk(scr_b, 2'h0);
    s0 = scr_d + 2'h2;
    repeat (4 * TK) @(posedge sys_clk_i);
    #1 chk(scr_d, s0);
    @(posedge sys_clk_i);
    frz <= 1'b1;
    repeat (DB + 4) @(posedge sys_clk_i);
    #1 s0 = scr_d;
    repeat (4 * TK) @(posedge sys_clk_i);
    #1 chk(scr_d, s0);
    @(posedge sys_clk_i);
    frz <= 1'b0;
    $display("test screens done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i);
      sw_req   <= cfg_t[i];
      want_rs  <= cfg_t[i][0];
      want_wet <= cfg_t[i][1];
      wait_sig(0, 1'b1, 20000, n);
      @(posedge sys_clk_i);
      if (prb_t[i]) want_wet <= ~cfg_t[i][1];
      else want_rs <= ~cfg_t[i][0];
      wait_sig(0, 1'b0, DB + 14, n);
      #1 chk(ind, 1'b1);
      @(posedge sys_clk_i);
      want_rs  <= cfg_t[i][0];
      want_wet <= cfg_t[i][1];
      repeat (20) @(posedge sys_clk_i);
      #1 chk({motor, ind}, 2'b01);
      wait_sig(0, 1'b1, tk_t[i] * TK + 20, n);
      chk(n + 20 >= tk_t[i] * TK, 1'b1);
      $display("test delay row %0d done", i);
    end
    @(posedge sys_clk_i);
    bounce <= 1'b1;
    @(posedge sys_clk_i);
    bounce <= 1'b0;
    repeat (DB + 12) @(posedge sys_clk_i);
    #1 chk({motor, ind}, 2'b10);
    $display("test chatter done");
    @(posedge sys_clk_i);
    oc_in <= 1'b1;
    wait_sig(1, 1'b1, 8, n);
    chk({motor, msg}, 2'b01);
    wait_sig(1, 1'b0, 180 * TK + 20, n);
    chk(n >= 179 * TK, 1'b1);
    wait_sig(1, 1'b1, 10, n);
    @(posedge sys_clk_i);
    oc_in <= 1'b0;
    wait_sig(0, 1'b1, 180 * TK + 30, n);
    rd(3'h3, 8'h07);
    rd(3'h1, 8'h01);
    $display("test over-current done");
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    want_rs <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < DB + 20; k++) begin
      @(posedge sys_clk_i);
      #1 chk(motor, 1'b0);
    end
    chk(ind, 1'b1);
    $display("test restart done");
    conclude();
  end
endmodule

`default_nettype wire
